// >>> core/dmd_decoder.sv
// Data-move decoder: opcode decode, operand shaping, timing and fault reporting
`timescale 1ns/100ps
module dmd_decoder
    import dmd_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_clk_en,
    input wire logic i_insn_valid,
    input wire logic [7:0] i_opcode,
    input wire logic [7:0] i_modrm,
    input wire logic [15:0] i_imm,
    input wire logic i_three_term_ea,
    input wire logic i_prot_mode,
    input wire logic i_prot_only_op,
    input wire logic i_lock_op,
    input wire logic i_desc_access,
    input wire logic [15:0] i_offset,
    input wire logic i_limit_fault,
    input wire logic i_rights_fault,
    input wire logic [1:0] i_seg_sel,
    input wire logic i_copro_op,
    input wire logic i_copro_xfer_fault,
    input wire logic i_priv_fault,
    input wire logic i_seg_absent,
    input wire logic i_far_xfer,
    input wire logic i_far_priv_fault,
    input wire logic i_target_limit_fault,
    input wire logic i_io_op,
    input wire logic i_selector_check,
    input wire logic i_selector_priv_fault,
    input wire logic i_flags_load,
    input wire logic i_flags_if,
    input wire logic [1:0] i_flags_io_privilege_level,
    input wire logic i_flags_nt,
    input wire logic [1:0] i_current_privilege_level,
    output logic o_valid,
    output logic [3:0] o_op,
    output logic o_to_reg,
    output logic o_word,
    output logic [2:0] o_reg_field,
    output logic [15:0] o_operand,
    output logic [5:0] o_cycles,
    output logic o_write_en,
    output logic o_bus_lock,
    output logic o_fault,
    output logic [4:0] o_fault_vector,
    output logic o_result_valid,
    output logic o_zero_flag_clr,
    output logic o_interrupt_enable,
    output logic [1:0] o_io_privilege_level,
    output logic o_nested_task_flag
);
    // Opcode match on fixed bits; care mask picks compared bits
    function automatic logic op_match(input logic [7:0] op, input logic [7:0] pat, input logic [7:0] care);
        op_match = ((op ^ pat) & care) == 8'h00;
    endfunction

    dmd_op_e op_kind;
    logic mem_op;
    logic to_reg;
    logic word_op;
    logic [15:0] operand;
    logic [5:0] cycles;
    logic chk_fault;
    logic [4:0] chk_vector;
    logic take;

    assign take = i_clk_en && i_insn_valid;
    assign mem_op = (op_kind == DMD_OP_MOV_ACC) || (op_kind == DMD_OP_PUSH_MEM) ||
                    ((op_kind inside {DMD_OP_MOV_RM, DMD_OP_MOV_IMM_RM, DMD_OP_SEG_LOAD, DMD_OP_SEG_STORE})
                     && i_modrm[7:6] != 2'h3);

    always_comb begin
        op_kind = DMD_OP_NONE;
        if (op_match(i_opcode, OP_MOV_SEG_LOAD, 8'hFF) || op_match(i_opcode, OP_MOV_SEG_STORE, 8'hFF)) begin
            op_kind = i_opcode[1] ? DMD_OP_SEG_LOAD : DMD_OP_SEG_STORE;
        end else if (op_match(i_opcode, OP_MOV_RM_FROM_REG, 8'hFC)) begin
            op_kind = DMD_OP_MOV_RM;
        end else if (op_match(i_opcode, OP_MOV_RM_IMM, 8'hFE) && i_modrm[5:3] == 3'h0) begin
            op_kind = DMD_OP_MOV_IMM_RM;
        end else if (op_match(i_opcode, OP_MOV_REG_IMM, 8'hF0)) begin
            op_kind = DMD_OP_MOV_IMM_REG;
        end else if (op_match(i_opcode, OP_MOV_ACC_FROM_MEM, 8'hFC)) begin
            op_kind = DMD_OP_MOV_ACC;
        end else if (op_match(i_opcode, OP_PUSH_MEM, 8'hFF) && i_modrm[5:3] == SUB_PUSH_MEM) begin
            op_kind = DMD_OP_PUSH_MEM;
        end else if (op_match(i_opcode, OP_PUSH_REG, 8'hF8)) begin
            op_kind = DMD_OP_PUSH_REG;
        end else if (op_match(i_opcode, OP_PUSH_SEG, 8'hE7)) begin
            op_kind = DMD_OP_PUSH_SEG;
        end else if (op_match(i_opcode, OP_PUSH_IMM, 8'hFD)) begin
            op_kind = DMD_OP_PUSH_IMM;
        end
    end

    // Direction and width; short forms carry w elsewhere or imply fixed meaning
    always_comb begin
        to_reg = 1'b0;
        word_op = i_opcode[0];
        case (op_kind)
            DMD_OP_MOV_RM: to_reg = i_opcode[1];
            DMD_OP_MOV_IMM_REG: begin
                to_reg = 1'b1;
                word_op = i_opcode[3];
            end
            DMD_OP_MOV_ACC: to_reg = ~i_opcode[1];
            DMD_OP_SEG_LOAD: begin
                to_reg = 1'b1;
                word_op = 1'b1;
            end
            DMD_OP_SEG_STORE, DMD_OP_PUSH_MEM, DMD_OP_PUSH_REG, DMD_OP_PUSH_SEG, DMD_OP_PUSH_IMM: word_op = 1'b1;
            default: to_reg = 1'b0;
        endcase
    end

    // Immediate shaping
    always_comb begin
        operand = i_imm;
        if (op_kind == DMD_OP_PUSH_IMM && i_opcode[1]) begin
            operand = {{8{i_imm[7]}}, i_imm[7:0]};
        end else if ((op_kind == DMD_OP_MOV_IMM_RM || op_kind == DMD_OP_MOV_IMM_REG) && !word_op) begin
            operand = {8'h00, i_imm[7:0]};
        end
    end

    // Cycle count: register form low, memory form high, extra clock for 3-term EA
    always_comb begin
        cycles = CYC_REG;
        case (op_kind)
            DMD_OP_MOV_RM: cycles = mem_op ? (to_reg ? CYC_MOV_LOAD_MEM : CYC_MOV_STORE_MEM) : CYC_REG;
            DMD_OP_MOV_IMM_RM, DMD_OP_SEG_STORE: cycles = mem_op ? CYC_MOV_STORE_MEM : CYC_REG;
            DMD_OP_MOV_ACC: cycles = i_opcode[1] ? CYC_ACC_STORE : CYC_ACC_LOAD;
            DMD_OP_SEG_LOAD: begin
                if (i_prot_mode) begin
                    cycles = mem_op ? CYC_SEG_LOAD_PROT_MEM : CYC_SEG_LOAD_PROT;
                end else begin
                    cycles = mem_op ? CYC_MOV_LOAD_MEM : CYC_REG;
                end
            end
            DMD_OP_PUSH_MEM: cycles = CYC_PUSH_MEM;
            DMD_OP_PUSH_REG, DMD_OP_PUSH_SEG, DMD_OP_PUSH_IMM: cycles = CYC_PUSH;
            default: cycles = CYC_REG;
        endcase
        if (mem_op && i_three_term_ea && op_kind != DMD_OP_MOV_ACC) begin
            cycles = 6'(cycles + CYC_EXTRA_EA);
        end
    end

    dmd_fault_check u_check (
        .i_prot_mode(i_prot_mode),
        .i_prot_only_op(i_prot_only_op),
        .i_word_op(word_op),
        .i_mem_op(mem_op || i_copro_op),
        .i_offset(i_offset),
        .i_limit_fault(i_limit_fault),
        .i_rights_fault(i_rights_fault),
        .i_seg_sel(i_seg_sel),
        .i_copro_op(i_copro_op),
        .i_copro_xfer_fault(i_copro_xfer_fault),
        .i_seg_load(op_kind == DMD_OP_SEG_LOAD),
        .i_priv_fault(i_priv_fault),
        .i_seg_absent(i_seg_absent),
        .i_far_xfer(i_far_xfer),
        .i_far_priv_fault(i_far_priv_fault),
        .i_target_limit_fault(i_target_limit_fault),
        .i_io_op(i_io_op),
        .i_current_privilege_level(i_current_privilege_level),
        .i_io_privilege_level(o_io_privilege_level),
        .o_fault(chk_fault),
        .o_vector(chk_vector)
    );

    // Decoded outputs, one cycle after the byte group is taken
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            o_valid <= 1'b0;
            o_op <= 4'h0;
            o_to_reg <= 1'b0;
            o_word <= 1'b0;
            o_reg_field <= 3'h0;
            o_operand <= 16'h0000;
            o_cycles <= 6'h00;
        end else if (i_clk_en) begin
            o_valid <= i_insn_valid;
            if (i_insn_valid) begin
                o_op <= op_kind;
                o_to_reg <= to_reg;
                o_word <= word_op;
                o_reg_field <= (op_kind == DMD_OP_MOV_IMM_REG || op_kind == DMD_OP_PUSH_REG) ?
                               i_opcode[2:0] : (op_kind == DMD_OP_PUSH_SEG ? {1'b0, i_opcode[4:3]} : i_modrm[5:3]);
                o_operand <= operand;
                o_cycles <= cycles;
            end
        end
    end

    // Fault pulse and write suppression
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            o_fault <= 1'b0;
            o_fault_vector <= 5'h00;
            o_write_en <= 1'b0;
        end else if (i_clk_en) begin
            o_fault <= take && chk_fault;
            if (take && chk_fault) begin
                o_fault_vector <= chk_vector;
            end
            o_write_en <= take && !chk_fault && op_kind != DMD_OP_NONE;
        end
    end

    // Bus lock: locking instructions and descriptor table traffic, prefix not needed
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            o_bus_lock <= 1'b0;
        end else if (i_clk_en) begin
            o_bus_lock <= (take && i_lock_op) || (i_prot_mode && i_desc_access);
        end
    end

    // Selector check: privilege breach yields no result and a clear zero flag
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            o_result_valid <= 1'b0;
            o_zero_flag_clr <= 1'b0;
        end else if (i_clk_en) begin
            o_result_valid <= take && i_selector_check && !i_selector_priv_fault;
            o_zero_flag_clr <= take && i_selector_check && i_selector_priv_fault;
        end
    end

    // Flag word: real mode pins privilege field and nested flag to zero
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            o_interrupt_enable <= 1'b0;
            o_io_privilege_level <= 2'h0;
            o_nested_task_flag <= 1'b0;
        end else if (i_clk_en) begin
            if (!i_prot_mode) begin
                o_io_privilege_level <= 2'h0;
                o_nested_task_flag <= 1'b0;
                if (take && i_flags_load) begin
                    o_interrupt_enable <= i_flags_if;
                end
            end else if (take && i_flags_load) begin
                o_nested_task_flag <= i_flags_nt;
                if (i_current_privilege_level <= o_io_privilege_level) begin
                    o_interrupt_enable <= i_flags_if;
                end
                if (i_current_privilege_level == PRIV_TOP) begin
                    o_io_privilege_level <= i_flags_io_privilege_level;
                end
            end
        end
    end


    // Rule checks beside the logic they guard
    fault_pulse_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (o_fault && i_clk_en && !take) |=> !o_fault)
        else $error("fault held without new cause");
    no_write_fault_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        !(o_fault && o_write_en)) else $error("write not suppressed on fault");
    real_io_privilege_level_zero_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (i_clk_en && !i_prot_mode) |=> (o_io_privilege_level == 2'h0 && !o_nested_task_flag))
        else $error("real mode privilege field not zero");
    undef_vec_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (take && !i_prot_mode && i_prot_only_op) |=> (o_fault && o_fault_vector == 5'h06))
        else $error("undefined opcode vector wrong");
    seg_overrun_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (take && !i_prot_mode && !i_prot_only_op && !(i_copro_op && i_copro_xfer_fault) && mem_op && word_op
         && i_offset == 16'hFFFF) |=> (o_fault && o_fault_vector == 5'h0D))
        else $error("segment overrun missed");
    io_priv_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (take && i_prot_mode && i_io_op && i_current_privilege_level > o_io_privilege_level)
        |=> (o_fault && o_fault_vector == 5'h0D)) else $error("I/O privilege fault missed");
    lock_op_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (take && i_lock_op) |=> o_bus_lock) else $error("bus lock not asserted");
    sign_ext_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (take && op_kind == DMD_OP_PUSH_IMM && i_opcode[1]) |=> (o_operand[15:8] == {8{o_operand[7]}}))
        else $error("immediate byte not sign extended");
    seg_load_cyc_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (take && i_prot_mode && op_kind == DMD_OP_SEG_LOAD && i_modrm[7:6] == 2'h3)
        |=> (o_cycles == 6'h11)) else $error("segment load cycle count wrong");
    direction_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (take && op_kind == DMD_OP_MOV_RM) |=> (o_to_reg == $past(i_opcode[1])))
        else $error("direction bit not honoured");
    width_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (take && op_kind == DMD_OP_MOV_RM) |=> (o_word == $past(i_opcode[0])))
        else $error("width bit not honoured");
    three_term_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (take && op_kind == DMD_OP_MOV_RM && mem_op && !i_opcode[1] && i_three_term_ea) |=> (o_cycles == 6'h04))
        else $error("three-term offset clock missing");
    desc_lock_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (i_clk_en && i_prot_mode && i_desc_access) |=> o_bus_lock)
        else $error("descriptor access not locked");
    if_guard_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (take && i_prot_mode && i_flags_load && i_current_privilege_level > o_io_privilege_level)
        |=> $stable(o_interrupt_enable)) else $error("interrupt flag changed without privilege");
    io_privilege_level_guard_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (take && i_prot_mode && i_flags_load && i_current_privilege_level != PRIV_TOP)
        |=> $stable(o_io_privilege_level)) else $error("privilege field changed outside level 0");
    sel_breach_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (take && i_selector_check && i_selector_priv_fault) |=> (o_zero_flag_clr && !o_result_valid))
        else $error("selector breach not reported");
endmodule

// >>> shared/dmd_pkg.sv
// Constants and types for the data-move decoder and fault checker
// Operation
// - Direction bit set writes register field
// - Width bit one selects word operation
// - Sign bit extends one immediate byte
// - Low count register, high memory, +1 three-term
// - Protected-only opcode in real mode raises 6
// - Real mode word at FFFF raises 13
// - Real mode keeps privilege field, nested flag zero
// - Real coprocessor operand past limit raises 9
// - Locking instructions assert bus lock always
// - Protected limit/rights fault 13, stack 12
// - Segment load privilege check, absent 11/12
// - Descriptor table accesses assert bus lock
// - Far transfer privilege breach raises 13
// - I/O instruction with low privilege raises 13
// - Flags load guards interrupt flag, privilege field
// - Selector check breach clears zero flag only
// - Coprocessor start fault 13/12, transfer 9
// - Transfer target beyond code limit raises 13; code checks it only with i_far_xfer set, in protected mode
// - Decode register/memory move opcode patterns
// - Decode immediate and accumulator move patterns
// - Segment register load/store, load 17/19 cycles protected
// - Decode stack push opcode patterns
package dmd_pkg;
    localparam logic [7:0] OP_MOV_RM_FROM_REG = 8'h88;
    localparam logic [7:0] OP_MOV_REG_FROM_RM = 8'h8A;
    localparam logic [7:0] OP_MOV_RM_IMM = 8'hC6;
    localparam logic [7:0] OP_MOV_REG_IMM = 8'hB0;
    localparam logic [7:0] OP_MOV_ACC_FROM_MEM = 8'hA0;
    localparam logic [7:0] OP_MOV_MEM_FROM_ACC = 8'hA2;
    localparam logic [7:0] OP_MOV_SEG_LOAD = 8'h8E;
    localparam logic [7:0] OP_MOV_SEG_STORE = 8'h8C;
    localparam logic [7:0] OP_PUSH_MEM = 8'hFF;
    localparam logic [2:0] SUB_PUSH_MEM = 3'h6;
    localparam logic [7:0] OP_PUSH_REG = 8'h50;
    localparam logic [7:0] OP_PUSH_SEG = 8'h06;
    localparam logic [7:0] OP_PUSH_IMM = 8'h68;
    localparam logic [15:0] OFFSET_LAST = 16'hFFFF;
    localparam logic [1:0] SEG_STACK = 2'h2;
    localparam logic [4:0] VEC_UNDEF = 5'h06;
    localparam logic [4:0] VEC_COPRO_OVR = 5'h09;
    localparam logic [4:0] VEC_NOT_PRESENT = 5'h0B;
    localparam logic [4:0] VEC_STACK = 5'h0C;
    localparam logic [4:0] VEC_GEN_PROT = 5'h0D;
    localparam logic [5:0] CYC_REG = 6'h02;
    localparam logic [5:0] CYC_MOV_STORE_MEM = 6'h03;
    localparam logic [5:0] CYC_MOV_LOAD_MEM = 6'h05;
    localparam logic [5:0] CYC_ACC_STORE = 6'h03;
    localparam logic [5:0] CYC_ACC_LOAD = 6'h05;
    localparam logic [5:0] CYC_SEG_LOAD_PROT = 6'h11;
    localparam logic [5:0] CYC_SEG_LOAD_PROT_MEM = 6'h13;
    localparam logic [5:0] CYC_PUSH = 6'h03;
    localparam logic [5:0] CYC_PUSH_MEM = 6'h05;
    localparam logic [5:0] CYC_EXTRA_EA = 6'h01;
    localparam logic [1:0] PRIV_TOP = 2'h0;
    typedef enum logic [3:0] {
        DMD_OP_NONE = 4'h0,
        DMD_OP_MOV_RM = 4'h1,
        DMD_OP_MOV_IMM_RM = 4'h2,
        DMD_OP_MOV_IMM_REG = 4'h3,
        DMD_OP_MOV_ACC = 4'h4,
        DMD_OP_SEG_LOAD = 4'h5,
        DMD_OP_SEG_STORE = 4'h6,
        DMD_OP_PUSH_MEM = 4'h7,
        DMD_OP_PUSH_REG = 4'h8,
        DMD_OP_PUSH_SEG = 4'h9,
        DMD_OP_PUSH_IMM = 4'hA
    } dmd_op_e;
endpackage

// >>> core/dmd_fault_check.sv
// Combinational exception checks for the data-move decoder
`timescale 1ns/100ps
module dmd_fault_check
    import dmd_pkg::*;
(
    input wire logic i_prot_mode,
    input wire logic i_prot_only_op,
    input wire logic i_word_op,
    input wire logic i_mem_op,
    input wire logic [15:0] i_offset,
    input wire logic i_limit_fault,
    input wire logic i_rights_fault,
    input wire logic [1:0] i_seg_sel,
    input wire logic i_copro_op,
    input wire logic i_copro_xfer_fault,
    input wire logic i_seg_load,
    input wire logic i_priv_fault,
    input wire logic i_seg_absent,
    input wire logic i_far_xfer,
    input wire logic i_far_priv_fault,
    input wire logic i_target_limit_fault,
    input wire logic i_io_op,
    input wire logic [1:0] i_current_privilege_level,
    input wire logic [1:0] i_io_privilege_level,
    output logic o_fault,
    output logic [4:0] o_vector
);
    logic stack_seg;
    assign stack_seg = (i_seg_sel == SEG_STACK);

    // Priority mirrors the order checks resolve in the pipe: opcode first
    always_comb begin
        o_fault = 1'b1;
        o_vector = VEC_GEN_PROT;
        if (!i_prot_mode && i_prot_only_op) begin
            o_vector = VEC_UNDEF;
        end else if (!i_prot_mode && i_copro_op && i_copro_xfer_fault) begin
            o_vector = VEC_COPRO_OVR;
        end else if (!i_prot_mode && i_mem_op && i_word_op && i_offset == OFFSET_LAST) begin
            o_vector = VEC_GEN_PROT;
        end else if (!i_prot_mode) begin
            o_fault = 1'b0;
        end else if (i_io_op && (i_current_privilege_level > i_io_privilege_level)) begin
            o_vector = VEC_GEN_PROT;
        end else if (i_far_xfer && (i_far_priv_fault || i_target_limit_fault)) begin
            o_vector = VEC_GEN_PROT;
        end else if (i_seg_load && i_priv_fault) begin
            o_vector = VEC_GEN_PROT;
        end else if (i_seg_load && i_seg_absent) begin
            o_vector = stack_seg ? VEC_STACK : VEC_NOT_PRESENT;
        end else if (i_mem_op && i_limit_fault && stack_seg) begin
            o_vector = VEC_STACK;
        end else if (i_mem_op && (i_limit_fault || i_rights_fault)) begin
            o_vector = VEC_GEN_PROT;
        end else if (i_copro_op && i_copro_xfer_fault) begin
            o_vector = VEC_COPRO_OVR;
        end else begin
            o_fault = 1'b0;
        end
    end
endmodule

// >>> sim/dmd_exec_model.sv
// Execution-unit model that counts accepted writes and reported faults
`timescale 1ns/100ps
module dmd_exec_model (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_valid,
    input wire logic i_write_en,
    input wire logic i_fault,
    output logic [7:0] o_writes,
    output logic [7:0] o_faults
);
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            o_writes <= 8'h00;
            o_faults <= 8'h00;
        end else begin
            // Write beside a fault would corrupt state, so both are tallied
            if (i_valid && i_write_en) o_writes <= o_writes + 8'h01;
            if (i_fault) o_faults <= o_faults + 8'h01;
        end
    end
endmodule

// >>> sim/dmd_decoder_tb_top.sv
// Self-checking bench for the data-move decoder
`timescale 1ns/100ps
module dmd_decoder_tb_top;
    import dmd_pkg::*;
    logic i_core_clk, i_rstn, i_clk_en, i_insn_valid, i_three_term_ea, i_prot_mode, i_prot_only_op;
    logic i_lock_op, i_desc_access, i_limit_fault, i_rights_fault, i_copro_op, i_copro_xfer_fault;
    logic i_priv_fault, i_seg_absent, i_far_xfer, i_far_priv_fault, i_target_limit_fault, i_io_op;
    logic i_selector_check, i_selector_priv_fault, i_flags_load, i_flags_if, i_flags_nt;
    logic [7:0] i_opcode, i_modrm, writes, faults;
    logic [15:0] i_imm, i_offset, o_operand;
    logic [1:0] i_seg_sel, i_flags_io_privilege_level, i_current_privilege_level, o_io_privilege_level;
    logic o_valid, o_to_reg, o_word, o_write_en, o_bus_lock, o_fault, o_result_valid, o_zero_flag_clr;
    logic o_interrupt_enable, o_nested_task_flag;
    logic [3:0] o_op;
    logic [2:0] o_reg_field;
    logic [5:0] o_cycles;
    logic [4:0] o_fault_vector;
    int n_fail, n_checks, exp_w, exp_f;
    dmd_decoder dut_u (.*);
    dmd_exec_model exec_u (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_valid(o_valid),
        .i_write_en(o_write_en), .i_fault(o_fault), .o_writes(writes), .o_faults(faults));
    initial begin
        i_core_clk = 1'b0;
        forever #50 i_core_clk = ~i_core_clk;
    end
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_dec(input logic [3:0] op, input logic wr, input logic [5:0] cyc);
        chk16({4'h0, o_valid, o_op, o_write_en, o_cycles}, {4'h1, op, wr, cyc});
    endtask
    task automatic chk_flt(input logic [4:0] vec);
        chk16({9'h000, o_fault, o_write_en, o_fault_vector}, {9'h000, 1'b1, 1'b0, vec});
    endtask
    task automatic clr;
        {i_three_term_ea, i_prot_only_op, i_lock_op, i_desc_access, i_limit_fault, i_rights_fault} <= 6'h00;
        {i_copro_op, i_copro_xfer_fault, i_priv_fault, i_seg_absent, i_far_xfer, i_far_priv_fault} <= 6'h00;
        {i_target_limit_fault, i_io_op, i_selector_check, i_selector_priv_fault, i_flags_load} <= 5'h00;
        i_offset <= 16'h0000;
        i_seg_sel <= 2'h0;
    endtask
    // Inputs change at a rising edge and are taken at the next one; results are read at the falling edge after that
    task automatic send(input logic [7:0] op, input logic [7:0] mrm, input logic [15:0] imm);
        i_opcode <= op;
        i_modrm <= mrm;
        i_imm <= imm;
        i_insn_valid <= 1'b1;
        @(posedge i_core_clk);
        i_insn_valid <= 1'b0;
        clr;
        @(negedge i_core_clk);
    endtask
    task automatic dec(input logic [7:0] op, input logic [7:0] mrm, input logic [15:0] imm,
                       input logic [3:0] eop, input logic wr, input logic [5:0] cyc);
        send(op, mrm, imm);
        chk_dec(eop, wr, cyc);
        if (wr) exp_w++;
        @(posedge i_core_clk);
    endtask
    task automatic flt(input logic [7:0] op, input logic [7:0] mrm, input logic [4:0] vec);
        send(op, mrm, 16'h0000);
        chk_flt(vec);
        exp_f++;
        @(posedge i_core_clk);
    endtask
    initial begin
        repeat (5000) @(posedge i_core_clk);
        n_fail++;
        $display("ERROR %0t: run timeout", $time);
        conclude;
    end
    initial begin
        {i_rstn, i_clk_en, i_insn_valid, i_prot_mode, i_flags_if, i_flags_nt} = 6'h12;
        {i_opcode, i_modrm, i_imm} = 32'h0000_0000;
        {i_flags_io_privilege_level, i_current_privilege_level} = 4'h0;
        clr;
        repeat (16) @(posedge i_core_clk);
        i_rstn <= 1'b1;
        @(negedge i_core_clk);
        chk16({o_valid, o_fault, o_write_en, o_bus_lock, o_io_privilege_level, o_cycles}, 16'h0000);
        @(posedge i_core_clk);
        dec(8'h8B, 8'hC1, 16'h0000, DMD_OP_MOV_RM, 1'b1, 6'h02);
        chk16({o_to_reg, o_word, o_reg_field}, 16'h0018);
        dec(8'h88, 8'h06, 16'h0000, DMD_OP_MOV_RM, 1'b1, 6'h03);
        chk16({o_to_reg, o_word}, 16'h0000);
        i_three_term_ea <= 1'b1;
        dec(8'h89, 8'h80, 16'h0000, DMD_OP_MOV_RM, 1'b1, 6'h04);
        i_three_term_ea <= 1'b1;
        dec(8'h8A, 8'h80, 16'h0000, DMD_OP_MOV_RM, 1'b1, 6'h06);
        dec(8'hC7, 8'h06, 16'h1234, DMD_OP_MOV_IMM_RM, 1'b1, 6'h03);
        chk16(o_operand, 16'h1234);
        dec(8'hBB, 8'h00, 16'hBEEF, DMD_OP_MOV_IMM_REG, 1'b1, 6'h02);
        chk16(o_operand, 16'hBEEF);
        chk16({o_word, o_reg_field}, 16'h000B);
        dec(8'hA1, 8'h00, 16'h0000, DMD_OP_MOV_ACC, 1'b1, 6'h05);
        dec(8'hA3, 8'h00, 16'h0000, DMD_OP_MOV_ACC, 1'b1, 6'h03);
        dec(8'h8C, 8'h06, 16'h0000, DMD_OP_SEG_STORE, 1'b1, 6'h03);
        dec(8'h8E, 8'hD8, 16'h0000, DMD_OP_SEG_LOAD, 1'b1, 6'h02);
        dec(8'hFF, 8'h36, 16'h0000, DMD_OP_PUSH_MEM, 1'b1, 6'h05);
        dec(8'h53, 8'h00, 16'h0000, DMD_OP_PUSH_REG, 1'b1, 6'h03);
        dec(8'h1E, 8'h00, 16'h0000, DMD_OP_PUSH_SEG, 1'b1, 6'h03);
        dec(8'h6A, 8'h00, 16'h0080, DMD_OP_PUSH_IMM, 1'b1, 6'h03);
        chk16(o_operand, 16'hFF80);
        dec(8'h68, 8'h00, 16'h8034, DMD_OP_PUSH_IMM, 1'b1, 6'h03);
        chk16(o_operand, 16'h8034);
        i_clk_en <= 1'b0;
        send(8'h8B, 8'hC1, 16'h0000);
        chk16({11'h000, o_valid, o_op}, {12'h000, DMD_OP_PUSH_IMM});
        $display("test decode done");
        @(posedge i_core_clk);
        i_clk_en <= 1'b1;
        i_prot_only_op <= 1'b1;
        flt(8'h8B, 8'hC1, 5'h06);
        i_offset <= 16'hFFFF;
        flt(8'h8B, 8'h06, 5'h0D);
        i_offset <= 16'hFFFF;
        dec(8'h8A, 8'h06, 16'h0000, DMD_OP_MOV_RM, 1'b1, 6'h05);
        {i_copro_op, i_copro_xfer_fault} <= 2'h3;
        flt(8'hD8, 8'h06, 5'h09);
        {i_flags_load, i_flags_io_privilege_level, i_flags_nt} <= 4'hF;
        send(8'h00, 8'hC0, 16'h0000);
        chk16({o_io_privilege_level, o_nested_task_flag}, 16'h0000);
        @(posedge i_core_clk);
        i_lock_op <= 1'b1;
        send(8'h86, 8'h06, 16'h0000);
        chk16({15'h0000, o_bus_lock}, 16'h0001);
        $display("test real mode done");
        @(posedge i_core_clk);
        i_prot_mode <= 1'b1;
        dec(8'h8E, 8'h06, 16'h0000, DMD_OP_SEG_LOAD, 1'b1, 6'h13);
        i_desc_access <= 1'b1;
        send(8'h8E, 8'hD8, 16'h0000);
        chk_dec(DMD_OP_SEG_LOAD, 1'b1, 6'h11);
        chk16({15'h0000, o_bus_lock}, 16'h0001);
        exp_w++;
        @(posedge i_core_clk);
        {i_limit_fault, i_seg_sel} <= 3'h6;
        flt(8'h8B, 8'h06, 5'h0C);
        i_limit_fault <= 1'b1;
        flt(8'h8B, 8'h06, 5'h0D);
        i_rights_fault <= 1'b1;
        flt(8'h89, 8'h06, 5'h0D);
        {i_seg_absent, i_seg_sel} <= 3'h5;
        flt(8'h8E, 8'h06, 5'h0B);
        {i_seg_absent, i_seg_sel} <= 3'h6;
        flt(8'h8E, 8'h06, 5'h0C);
        i_priv_fault <= 1'b1;
        flt(8'h8E, 8'hD8, 5'h0D);
        {i_far_xfer, i_far_priv_fault} <= 2'h3;
        flt(8'hEA, 8'h00, 5'h0D);
        {i_far_xfer, i_target_limit_fault} <= 2'h3;
        flt(8'hCB, 8'h00, 5'h0D);
        {i_copro_op, i_limit_fault} <= 2'h3;
        flt(8'hD9, 8'h06, 5'h0D);
        {i_copro_op, i_limit_fault, i_seg_sel} <= 4'hE;
        flt(8'hD9, 8'h06, 5'h0C);
        {i_copro_op, i_copro_xfer_fault} <= 2'h3;
        flt(8'hD9, 8'h06, 5'h09);
        {i_flags_load, i_flags_if, i_flags_io_privilege_level, i_flags_nt} <= 5'h1D;
        send(8'h00, 8'hC0, 16'h0000);
        chk16({o_interrupt_enable, o_io_privilege_level, o_nested_task_flag}, 16'h000D);
        @(posedge i_core_clk);
        i_current_privilege_level <= 2'h3;
        {i_flags_load, i_flags_if, i_flags_io_privilege_level, i_flags_nt} <= 5'h10;
        send(8'h00, 8'hC0, 16'h0000);
        chk16({o_interrupt_enable, o_io_privilege_level, o_nested_task_flag}, 16'h000C);
        @(posedge i_core_clk);
        i_io_op <= 1'b1;
        flt(8'hE4, 8'h00, 5'h0D);
        {i_io_op, i_current_privilege_level} <= 3'h6;
        send(8'hE4, 8'h00, 16'h0000);
        chk16({15'h0000, o_fault}, 16'h0000);
        @(posedge i_core_clk);
        {i_selector_check, i_selector_priv_fault} <= 2'h3;
        send(8'h0F, 8'h00, 16'h0000);
        chk16({o_result_valid, o_zero_flag_clr, o_fault}, 16'h0002);
        @(posedge i_core_clk);
        i_selector_check <= 1'b1;
        send(8'h0F, 8'h00, 16'h0000);
        chk16({o_result_valid, o_zero_flag_clr, o_fault}, 16'h0004);
        @(posedge i_core_clk);
        chk16({writes, faults}, {exp_w[7:0], exp_f[7:0]});
        $display("test protected mode done");
        conclude;
    end
endmodule
